// ---- hw/fpec_pkg.sv ----
// Constants, field layout and types of the flash program/erase controller
package fpec_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  // Fixed RAM window used for flash emulation
  localparam logic [23:0] OVL_RAM_BASE = 24'hffe000;
  localparam logic [23:0] OVL_RAM_LAST = 24'hffe3ff;
  localparam int OVL_OFS_W = 10;
  localparam int OVL_SEL_W = 2;
  // Program latch geometry
  localparam int LATCH_BYTES = 128;
  localparam int LATCH_IDX_W = 7;
  localparam int LATCH_CNT_W = 8;
  localparam logic [7:0] LATCH_FULL_CNT = 8'h80;
  // Field positions of flash_ctrl_one
  localparam int C1_SWE = 6;
  localparam int C1_EV = 3;
  localparam int C1_PV = 2;
  localparam int C1_E = 1;
  localparam int C1_P = 0;
  // Field position of flash_ctrl_two
  localparam int C2_FLASH_ERROR_FLAG = 7;
  // Field positions of ram_overlay_control
  localparam int OVL_EN = 3;
  localparam int OVL_SEL_HI = 2;
  localparam int OVL_SEL_MID = 1;
  localparam int OVL_SEL_LO = 0;
  // Values after reset
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] ERASE_BLOCK_SEL_ONE_RST = 8'h00;
  localparam logic [7:0] OVL_RST = 8'h00;
  // Verify dummy write data
  localparam logic [7:0] VERIFY_DUMMY = 8'hff;
  // Flash wake time after standby
  localparam int CLK_MHZ = 100;
  localparam int WAKE_US = 20;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int WAKE_W = 12;
  typedef enum logic [2:0] {
    FPEC_IDLE,
    FPEC_PROG,
    FPEC_PVER,
    FPEC_ERASE,
    FPEC_EVER
  } fpec_mode_t;
endpackage

// ---- hw/fpec_ovl_if.sv ----
// Interface between the controller and its overlay address mapper
`timescale 1ns/1ps
interface fpec_ovl_if;
  logic [23:0] addr;
  logic en;
  logic [1:0] blk;
  logic flash_hit;
  logic ram_hit;
  logic [9:0] offset;
  modport mapper (input addr, input en, input blk, output flash_hit, output ram_hit,
    output offset);
  modport user (output addr, output en, output blk, input flash_hit, input ram_hit,
    input offset);
endinterface

// ---- hw/fpec_ovl_map.sv ----
// Overlay mapper: folds one low erase block onto the fixed RAM window
`timescale 1ns/1ps
module fpec_ovl_map (
  fpec_ovl_if.mapper ovl
);
  logic [23:0] blk_base;

  // Block base is the select field times one kilobyte
  assign blk_base = {12'h000, ovl.blk, 10'h000};

  // Both address views reach the same RAM while enabled
  always_comb begin
    ovl.ram_hit = ovl.en && (ovl.addr >= fpec_pkg::OVL_RAM_BASE) &&
      (ovl.addr <= fpec_pkg::OVL_RAM_LAST);
    ovl.flash_hit = ovl.en && (ovl.addr[23:10] == blk_base[23:10]);
    ovl.offset = ovl.addr[9:0];
  end
endmodule

// ---- hw/fpec_top.sv ----
// Flash program/erase controller with RAM overlay and protection
`timescale 1ns/1ps
//
// Contract
// RQ1: Overlay maps RAM window onto one low block
// RQ2: Upper two select bits choose block, low ignored
// RQ3: Overlay RAM answers at RAM and flash addresses
// RQ4: Overlay enabled protects all blocks from program/erase
// RQ5: Overlay disable returns flash addresses to array
// RQ6: Control register one picks one of four modes
// RQ7: Software always sends full 128 bytes, H'FF padded
// RQ8: Latch address and 128 bytes; aligned start only
// RQ9: Program pulse lasts exactly while program bit set
// RQ10: Erase pulse lasts exactly while erase bit set
// RQ11: Software arms watchdog around each pulse
// RQ12: Dummy H'FF write sets verify longword address
// RQ13: Program loop limited to 1,000 repeats by software
// RQ14: Erase loop limited to 100 repeats by software
// RQ15: Software never programs an address twice
// RQ16: Software selects one block per erase
// RQ17: Interrupts blocked while programming, erasing or booting
// RQ18: Reset or standby aborts and clears control registers
// RQ19: Write enable clear ignores program and erase bits
// RQ20: Block register bits enable erase; zero protects all
// RQ21: Read, exception or sleep during operation sets error
// RQ22: Error keeps registers, aborts, refuses reentry, allows verify
// RQ23: Only power-on reset clears error protection
// RQ24: Standby halts flash; resume waits twenty microseconds
// RQ25: Error flag readable in control two until power-on
module fpec_top #(
  parameter int N_BLK_TWO = 4,
  parameter logic [23:0] FLASH_LAST = 24'h01ffff
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ctl1_we,
  input wire logic [7:0] ctl1_wdata,
  input wire logic erase_block_sel_one_we,
  input wire logic [7:0] erase_block_sel_one_wdata,
  input wire logic erase_block_sel_two_we,
  input wire logic [N_BLK_TWO-1:0] erase_block_sel_two_wdata,
  input wire logic ovl_we,
  input wire logic [7:0] ovl_wdata,
  input wire logic standby_req,
  input wire logic boot_running,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic [23:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic exc_start,
  input wire logic sleep_exec,
  input wire logic [6:0] latch_rd_idx,
  output logic [7:0] flash_ctrl_one_q,
  output logic [7:0] flash_ctrl_two_q,
  output logic [7:0] erase_block_sel_one_q,
  output logic [N_BLK_TWO-1:0] erase_block_sel_two_q,
  output logic [7:0] ram_overlay_control_q,
  output fpec_pkg::fpec_mode_t mode_q,
  output logic program_pulse_q,
  output logic erase_pulse_q,
  output logic [8+N_BLK_TWO-1:0] erase_target_q,
  output logic irq_block_q,
  output logic route_ram_q,
  output logic [9:0] ram_offset_q,
  output logic [23:0] verify_addr_q,
  output logic verify_armed_q,
  output logic [7:0] latch_count_q,
  output logic [23:0] latch_base_q,
  output logic latch_full_q,
  output logic [7:0] latch_rd_data_q,
  output logic flash_halt_q,
  output logic flash_ready_q
);
  localparam int NB = 8 + N_BLK_TWO;
  localparam logic [11:0] WAKE_CNT = 12'(fpec_pkg::WAKE_CYC);

  // Flash array address decode, shared by several checks
  function automatic logic is_flash(input logic [23:0] a);
    is_flash = (a <= FLASH_LAST);
  endfunction

  // Address and select bundle shared with the overlay mapper
  fpec_ovl_if ovl ();

  logic any_rst;
  logic hw_clr;
  logic software_write_enable;
  logic p_bit;
  logic e_bit;
  logic pv_bit;
  logic ev_bit;
  logic ovl_en;
  logic flash_error_flag;
  logic busy;
  logic flash_rd;
  logic err_event;
  logic pe_allowed;
  logic [NB-1:0] blk_mask;
  logic prog_d;
  logic erase_d;
  fpec_pkg::fpec_mode_t mode_d;
  logic latch_we;
  logic latch_start_ok;
  logic latch_drop;
  logic dummy_wr;
  logic [7:0] latch_mem [fpec_pkg::LATCH_BYTES];
  logic [11:0] wake_cnt_q;

  // Field views of the control registers
  assign software_write_enable = flash_ctrl_one_q[fpec_pkg::C1_SWE];
  assign p_bit = flash_ctrl_one_q[fpec_pkg::C1_P];
  assign e_bit = flash_ctrl_one_q[fpec_pkg::C1_E];
  assign pv_bit = flash_ctrl_one_q[fpec_pkg::C1_PV];
  assign ev_bit = flash_ctrl_one_q[fpec_pkg::C1_EV];
  assign ovl_en = ram_overlay_control_q[fpec_pkg::OVL_EN];
  assign flash_error_flag = flash_ctrl_two_q[fpec_pkg::C2_FLASH_ERROR_FLAG];
  assign busy = program_pulse_q | erase_pulse_q;

  // Either reset input resets; standby also clears the protected set
  assign any_rst = !rst_n || !por_n;
  assign hw_clr = any_rst || standby_req; // [RQ18]

  // Overlay mapper sees the CPU address; low select bit is dropped
  assign ovl.addr = cpu_addr;
  assign ovl.en = ovl_en; // [RQ5]
  assign ovl.blk = {ram_overlay_control_q[fpec_pkg::OVL_SEL_HI],
    ram_overlay_control_q[fpec_pkg::OVL_SEL_MID]}; // [RQ2]

  fpec_ovl_map u_map (
    .ovl(ovl.mapper)
  );

  // A flash read that the overlay does not capture reaches the array
  assign flash_rd = cpu_valid && !cpu_write && is_flash(cpu_addr) && !ovl.flash_hit;

  // Runaway signs while a pulse is applied
  assign err_event = busy && (flash_rd || exc_start || sleep_exec); // [RQ21]

  // All five protections gate entry to program or erase
  assign pe_allowed = software_write_enable && !ovl_en && !flash_error_flag && !standby_req &&
    flash_ready_q; // [RQ4] [RQ19] [RQ22]

  // Block enables from both block registers
  assign blk_mask = {erase_block_sel_two_q, erase_block_sel_one_q};

  // Pulses follow their bits with one cycle lag on both edges
  // Program has priority when software sets both request bits
  assign prog_d = pe_allowed && p_bit && !err_event && !hw_clr; // [RQ9]
  assign erase_d = pe_allowed && e_bit && !p_bit && (|blk_mask) && !err_event &&
    !hw_clr; // [RQ10] [RQ20]

  // Mode decode; verify stays reachable under error protection
  always_comb begin
    if (prog_d) begin
      mode_d = fpec_pkg::FPEC_PROG; // [RQ6]
    end else if (erase_d) begin
      mode_d = fpec_pkg::FPEC_ERASE;
    end else if (software_write_enable && pv_bit && !standby_req && !hw_clr) begin
      mode_d = fpec_pkg::FPEC_PVER; // [RQ22]
    end else if (software_write_enable && ev_bit && !standby_req && !hw_clr) begin
      mode_d = fpec_pkg::FPEC_EVER;
    end else begin
      mode_d = fpec_pkg::FPEC_IDLE;
    end
  end

  // Control register one: cleared by reset and by standby
  always_ff @(posedge clk_sys) begin
    if (hw_clr) begin
      flash_ctrl_one_q <= fpec_pkg::CTL1_RST; // [RQ18]
    end else if (ctl1_we) begin
      flash_ctrl_one_q <= ctl1_wdata;
    end
  end

  // Control register two holds only the error flag; the power-on reset clear wins over a set
  // A plain reset keeps the flag, so a runaway loop stays fenced off
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      flash_ctrl_two_q <= fpec_pkg::CTL2_RST; // [RQ23]
    end else if (err_event) begin
      flash_ctrl_two_q[fpec_pkg::C2_FLASH_ERROR_FLAG] <= 1'b1; // [RQ21] [RQ25]
    end
  end

  // Block register one: cleared with control register one
  always_ff @(posedge clk_sys) begin
    if (hw_clr) begin
      erase_block_sel_one_q <= fpec_pkg::ERASE_BLOCK_SEL_ONE_RST; // [RQ18]
    end else if (erase_block_sel_one_we) begin
      erase_block_sel_one_q <= erase_block_sel_one_wdata; // [RQ20]
    end
  end

  // Block register two survives standby
  // Upper selections are not part of the set cleared on standby
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      erase_block_sel_two_q <= '0;
    end else if (erase_block_sel_two_we) begin
      erase_block_sel_two_q <= erase_block_sel_two_wdata;
    end
  end

  // Overlay control; reserved upper bits read as zero
  // The low select bit is stored for readback but plays no part in mapping
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      ram_overlay_control_q <= fpec_pkg::OVL_RST;
    end else if (ovl_we) begin
      ram_overlay_control_q <= {4'h0, ovl_wdata[3:0]}; // [RQ1]
    end
  end

  // Program and erase pulses, aborted in the cycle an error is seen
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      program_pulse_q <= 1'b0;
      erase_pulse_q <= 1'b0;
      mode_q <= fpec_pkg::FPEC_IDLE;
    end else begin
      program_pulse_q <= prog_d; // [RQ9] [RQ22]
      erase_pulse_q <= erase_d; // [RQ10]
      mode_q <= mode_d; // [RQ6]
    end
  end

  // Per-block erase drive; only enabled blocks see the pulse
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_blk
      always_ff @(posedge clk_sys) begin
        if (any_rst) begin
          erase_target_q[gi] <= 1'b0;
        end else begin
          erase_target_q[gi] <= erase_d && blk_mask[gi]; // [RQ20]
        end
      end
    end
  endgenerate

  // Interrupts held off for the whole pulse and while booting
  // Built from the same terms as the pulses so both change on one edge
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      irq_block_q <= 1'b0;
    end else begin
      irq_block_q <= prog_d || erase_d || boot_running; // [RQ17]
    end
  end

  // RAM routing for both the RAM window and the overlaid flash block
  // The offset is captured every cycle and only means something with the route flag
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      route_ram_q <= 1'b0;
      ram_offset_q <= '0;
    end else begin
      route_ram_q <= cpu_valid && (ovl.flash_hit || ovl.ram_hit); // [RQ1] [RQ3]
      ram_offset_q <= ovl.offset; // [RQ3]
    end
  end

  // Latch accepts writes only in the setup phase, before any pulse
  assign latch_start_ok = (cpu_addr[6:0] == 7'h00); // [RQ8]
  assign latch_we = cpu_valid && cpu_write && is_flash(cpu_addr) && !ovl.flash_hit &&
    software_write_enable && !p_bit && !e_bit && !pv_bit && !ev_bit && !ovl_en && !latch_full_q &&
    ((latch_count_q != 8'h00) || latch_start_ok);
  // The latch empties when a program pulse ends, ready for the next unit
  // A byte written in the cycle the pulse ends is lost; software only
  // loads the latch before it sets the program bit
  assign latch_drop = program_pulse_q && !prog_d;

  // Latch bookkeeping: first byte also captures the unit address
  always_ff @(posedge clk_sys) begin
    if (hw_clr || latch_drop) begin
      latch_count_q <= '0;
      latch_base_q <= '0;
      latch_full_q <= 1'b0;
    end else if (latch_we) begin
      if (latch_count_q == 8'h00) begin
        latch_base_q <= cpu_addr; // [RQ8]
      end
      latch_count_q <= latch_count_q + 8'h01;
      latch_full_q <= (latch_count_q == fpec_pkg::LATCH_FULL_CNT - 8'h01); // [RQ7]
    end
  end

  // Latch storage; no reset since contents only count once full
  always_ff @(posedge clk_sys) begin
    if (latch_we) begin
      latch_mem[latch_count_q[6:0]] <= cpu_wdata; // [RQ8]
    end
  end

  // Registered read port towards the array write circuit
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      latch_rd_data_q <= '0;
    end else begin
      latch_rd_data_q <= latch_mem[latch_rd_idx];
    end
  end

  // Dummy write picks the longword the array returns in verify
  assign dummy_wr = cpu_valid && cpu_write && is_flash(cpu_addr) &&
    (cpu_wdata == fpec_pkg::VERIFY_DUMMY) && (cpu_addr[1:0] == 2'b00) &&
    ((mode_q == fpec_pkg::FPEC_PVER) || (mode_q == fpec_pkg::FPEC_EVER));

  // Verify arming is dropped as soon as verify mode is left; the address is kept
  // A dummy write outside the verify modes leaves the address untouched
  always_ff @(posedge clk_sys) begin
    if (hw_clr) begin
      verify_addr_q <= '0;
      verify_armed_q <= 1'b0;
    end else if (dummy_wr) begin
      verify_addr_q <= cpu_addr; // [RQ12]
      verify_armed_q <= 1'b1;
    end else if ((mode_d != fpec_pkg::FPEC_PVER) && (mode_d != fpec_pkg::FPEC_EVER)) begin
      verify_armed_q <= 1'b0;
    end
  end

  // Standby halts the array; wake time is enforced here as well, so a
  // short software wait setting cannot start program or erase on an unstable array
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      flash_halt_q <= 1'b0;
      wake_cnt_q <= WAKE_CNT;
      flash_ready_q <= 1'b1;
    end else if (standby_req) begin
      flash_halt_q <= 1'b1; // [RQ24]
      wake_cnt_q <= '0;
      flash_ready_q <= 1'b0;
    end else begin
      flash_halt_q <= 1'b0;
      if (wake_cnt_q != WAKE_CNT) begin
        wake_cnt_q <= wake_cnt_q + 12'h001;
      end
      flash_ready_q <= (wake_cnt_q >= WAKE_CNT - 12'h001); // [RQ24]
    end
  end
endmodule

// ---- verification/fpec_props.sv ----
// Port-level assertion checker of the flash program/erase controller
`timescale 1ns/1ps
module fpec_props #(
  parameter int N_BLK_TWO = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic standby_req,
  input wire logic boot_running,
  input wire logic [7:0] flash_ctrl_one_q,
  input wire logic [7:0] flash_ctrl_two_q,
  input wire logic [7:0] ram_overlay_control_q,
  input wire fpec_pkg::fpec_mode_t mode_q,
  input wire logic program_pulse_q,
  input wire logic erase_pulse_q,
  input wire logic [8+N_BLK_TWO-1:0] erase_target_q,
  input wire logic irq_block_q,
  input wire logic [7:0] latch_count_q,
  input wire logic latch_full_q,
  input wire logic flash_halt_q,
  input wire logic flash_ready_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !por_n);
  a_swe_gate: assert property (program_pulse_q |-> $past(flash_ctrl_one_q[6]))
    else $error("program pulse without write enable");
  a_prog_hold: assert property (!flash_ctrl_one_q[0] |=> !program_pulse_q)
    else $error("program pulse outlives its bit");
  a_erase_hold: assert property (!flash_ctrl_one_q[1] |=> !erase_pulse_q)
    else $error("erase pulse outlives its bit");
  a_ovl_protect: assert property (ram_overlay_control_q[3] |=>
    !(program_pulse_q || erase_pulse_q))
    else $error("pulse while overlay enabled");
  a_err_refuse: assert property (flash_ctrl_two_q[7] |->
    !(program_pulse_q || erase_pulse_q))
    else $error("pulse while error flag set");
  a_err_cause: assert property ($rose(flash_ctrl_two_q[7]) |->
    $past(program_pulse_q || erase_pulse_q))
    else $error("error flag set outside an operation");
  a_err_sticky: assert property (disable iff (!por_n)
    flash_ctrl_two_q[7] |=> flash_ctrl_two_q[7])
    else $error("error flag lost without power-on reset");
  a_irq_block: assert property ((program_pulse_q || erase_pulse_q) |-> irq_block_q)
    else $error("interrupts open during an operation");
  a_boot_block: assert property (boot_running ##1 boot_running |-> irq_block_q)
    else $error("interrupts open while booting");
  a_target_gate: assert property ((erase_target_q != '0) |-> erase_pulse_q)
    else $error("block erase drive without erase pulse");
  a_standby_stop: assert property (standby_req |=>
    flash_halt_q && !flash_ready_q && flash_ctrl_one_q == 8'h00)
    else $error("standby did not halt and clear");
  a_mode_prog: assert property (program_pulse_q |-> mode_q == fpec_pkg::FPEC_PROG)
    else $error("program pulse outside program mode");
  a_latch_full: assert property (latch_full_q |->
    latch_count_q == fpec_pkg::LATCH_FULL_CNT)
    else $error("latch full at wrong count");
  // Main scenarios reached
  c_prog: cover property ($rose(program_pulse_q));
  c_erase: cover property ($rose(erase_pulse_q));
  c_error: cover property ($rose(flash_ctrl_two_q[7]));
endmodule

// ---- verification/fpec_cpu_model.sv ----
// Behavioural CPU running the control program from RAM
`timescale 1ns/1ps
module fpec_cpu_model (
  input wire logic clk_sys,
  output logic cpu_valid,
  output logic cpu_write,
  output logic [23:0] cpu_addr,
  output logic [7:0] cpu_wdata
);
  initial begin
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
    cpu_addr = 24'h000000;
    cpu_wdata = 8'h00;
  end
  // One access every other cycle; idle lines show the inverse so stale values never match
  task automatic acc(input logic w, input logic [23:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_valid = 1'b1;
    cpu_write = w;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk_sys);
    cpu_valid = 1'b0;
    cpu_write = ~w;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask
  // Whole program unit from an aligned base, unused bytes padded as erased
  task automatic send_unit(input logic [23:0] base, input logic [7:0] b [128], input int n);
    for (int i = 0; i < 128; i++) begin
      acc(1'b1, base + 24'(i), (i < n) ? b[i] : 8'hff);
    end
  endtask
endmodule

// ---- verification/test_fpec_top.sv ----
// Self-checking testbench of the flash program/erase controller
`timescale 1ns/1ps
module test_fpec_top;
  logic clk_sys, rst_n, por_n, ctl1_we, erase_block_sel_one_we, erase_block_sel_two_we, ovl_we;
  logic [7:0] ctl1_wdata, erase_block_sel_one_wdata, ovl_wdata, c1, c2, eb1, ovl, lcnt, lrd;
  logic [3:0] erase_block_sel_two_wdata, eb2;
  logic standby_req, boot_running, exc_start, sleep_exec, cpu_valid, cpu_write;
  logic [6:0] latch_rd_idx;
  logic [23:0] cpu_addr, vaddr, lbase, a;
  logic [7:0] cpu_wdata;
  fpec_pkg::fpec_mode_t mode;
  logic ppul, epul, irqb, rram, varm, lfull, halt, rdy;
  logic [11:0] etgt;
  logic [9:0] roff, off;
  logic [7:0] buf_b [128];
  fpec_pkg::fpec_mode_t mtab [4] = '{fpec_pkg::FPEC_PROG, fpec_pkg::FPEC_ERASE,
    fpec_pkg::FPEC_PVER, fpec_pkg::FPEC_EVER};
  int fail_count, total_checks, cyc, seed, k, n;
  fpec_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n), .ctl1_we(ctl1_we),
    .ctl1_wdata(ctl1_wdata), .erase_block_sel_one_we(erase_block_sel_one_we), .erase_block_sel_one_wdata(erase_block_sel_one_wdata), .erase_block_sel_two_we(erase_block_sel_two_we),
    .erase_block_sel_two_wdata(erase_block_sel_two_wdata), .ovl_we(ovl_we), .ovl_wdata(ovl_wdata), .standby_req(standby_req),
    .boot_running(boot_running), .cpu_valid(cpu_valid), .cpu_write(cpu_write),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .exc_start(exc_start), .sleep_exec(sleep_exec),
    .latch_rd_idx(latch_rd_idx), .flash_ctrl_one_q(c1), .flash_ctrl_two_q(c2),
    .erase_block_sel_one_q(eb1), .erase_block_sel_two_q(eb2), .ram_overlay_control_q(ovl),
    .mode_q(mode), .program_pulse_q(ppul), .erase_pulse_q(epul), .erase_target_q(etgt),
    .irq_block_q(irqb), .route_ram_q(rram), .ram_offset_q(roff), .verify_addr_q(vaddr),
    .verify_armed_q(varm), .latch_count_q(lcnt), .latch_base_q(lbase), .latch_full_q(lfull),
    .latch_rd_data_q(lrd), .flash_halt_q(halt), .flash_ready_q(rdy));
  fpec_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_valid(cpu_valid), .cpu_write(cpu_write),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tick(input int m);
    repeat (m) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected routing of one access from the overlay window rules
  function automatic logic exp_route(input logic [23:0] ad, input logic [7:0] sel);
    exp_route = sel[3] && ((ad[23:10] == {12'h000, sel[2:1]}) ||
      ((ad >= fpec_pkg::OVL_RAM_BASE) && (ad <= fpec_pkg::OVL_RAM_LAST)));
  endfunction
  // One strobe per register write; all share the data byte
  task automatic wreg(input int r, input logic [7:0] d);
    @(negedge clk_sys);
    {ctl1_wdata, erase_block_sel_one_wdata, ovl_wdata, erase_block_sel_two_wdata} = {d, d, d, d[3:0]};
    {ctl1_we, erase_block_sel_one_we, erase_block_sel_two_we, ovl_we} = {r == 0, r == 1, r == 2, r == 3};
    @(negedge clk_sys);
    {ctl1_we, erase_block_sel_one_we, erase_block_sel_two_we, ovl_we} = 4'h0;
  endtask
  task automatic do_reset(input logic por);
    @(negedge clk_sys);
    rst_n = 1'b0;
    por_n = ~por;
    tick(5);
    {rst_n, por_n} = 2'b11;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    seed = 32'h83d96094;
    {rst_n, por_n, ctl1_we, erase_block_sel_one_we, erase_block_sel_two_we, ovl_we, standby_req} = 7'h00;
    {boot_running, exc_start, sleep_exec, latch_rd_idx} = 10'h000;
    {ctl1_wdata, erase_block_sel_one_wdata, ovl_wdata, erase_block_sel_two_wdata} = 28'h0000000;
    do_reset(1'b1);
    chk({c1, c2, eb1, ovl}, 32'h00000000);
    chk(rdy, 1'b1);
    // Write enable clear refuses both requests
    wreg(0, 8'h03);
    tick(1);
    chk({ppul, epul}, 2'b00);
    wreg(1, 8'h00);
    wreg(0, 8'h42);
    tick(1);
    chk(epul, 1'b0);
    k = $random(seed) & 7;
    wreg(1, 8'h01 << k);
    tick(1);
    chk(epul, 1'b1);
    chk(etgt, 32'h1 << k);
    // Every mode, with a verify dummy write in the two verify modes
    for (int i = 0; i < 4; i++) begin
      wreg(0, 8'h40);
      tick(1);
      chk({ppul, epul}, 2'b00);
      wreg(0, 8'h40 | (8'h01 << i));
      tick(1);
      chk(mode, mtab[i]);
      chk(irqb, i < 2);
      if (i > 1) begin
        a = $random(seed) & 24'h01fffc;
        u_cpu.acc(1'b1, a, fpec_pkg::VERIFY_DUMMY);
        chk({varm, vaddr}, {1'b1, a});
      end
    end
    wreg(0, 8'h40);
    boot_running = 1'b1;
    tick(2);
    chk(irqb, 1'b1);
    chk(varm, 1'b0);
    boot_running = 1'b0;
    // Overlay of each select code, low select bit included
    for (int s = 0; s < 8; s++) begin
      wreg(3, 8'h08 | 8'(s));
      chk(ovl, 8'h08 | 8'(s));
      off = $random(seed);
      u_cpu.acc(1'b0, fpec_pkg::OVL_RAM_BASE | 24'(off), 8'h00);
      chk({rram, roff}, {1'b1, off});
      u_cpu.acc(1'b0, (24'(s / 2) << 10) | 24'(off), 8'h00);
      chk({rram, roff}, {1'b1, off});
      u_cpu.acc(1'b0, 24'h001000 | 24'(off), 8'h00);
      chk(rram, exp_route(24'h001000 | 24'(off), 8'h08 | 8'(s)));
    end
    wreg(0, 8'h41);
    tick(1);
    chk(ppul, 1'b0);
    wreg(0, 8'h40);
    wreg(3, 8'h00);
    u_cpu.acc(1'b0, 24'h000c00 | 24'(off), 8'h00);
    chk(rram, exp_route(24'h000c00 | 24'(off), 8'h00));
    // Latch: misaligned start ignored, then a padded unit, overflow refused
    a = ($random(seed) & 24'h01ff00) | 24'h000080;
    u_cpu.acc(1'b1, a + 24'h1, 8'h55);
    chk(lcnt, 8'h00);
    for (int i = 0; i < 128; i++) buf_b[i] = $random(seed);
    n = ($random(seed) & 63) + 64;
    u_cpu.send_unit(a, buf_b, n);
    u_cpu.acc(1'b1, a, 8'h00);
    chk({lfull, lcnt}, {1'b1, fpec_pkg::LATCH_FULL_CNT});
    chk(lbase, a);
    for (int i = 0; i < 128; i += 31) begin
      latch_rd_idx = 7'(i);
      tick(1);
      chk(lrd, (i < n) ? buf_b[i] : 8'hff);
    end
    wreg(0, 8'h41);
    tick(1);
    wreg(0, 8'h40);
    tick(1);
    chk(lcnt, 8'h00);
    // Each error cause during a program pulse
    for (int c = 0; c < 3; c++) begin
      do_reset(1'b1);
      wreg(0, 8'h41);
      tick(1);
      chk(ppul, 1'b1);
      if (c == 0) begin
        u_cpu.acc(1'b0, 24'h000400, 8'h00);
      end else begin
        {exc_start, sleep_exec} = {c == 1, c == 2};
        tick(1);
        {exc_start, sleep_exec} = 2'b00;
      end
      tick(1);
      chk({c2, ppul, c1}, {8'h80, 1'b0, 8'h41});
    end
    wreg(0, 8'h40);
    wreg(0, 8'h41);
    tick(1);
    chk(ppul, 1'b0);
    wreg(0, 8'h44);
    tick(1);
    chk(mode, fpec_pkg::FPEC_PVER);
    do_reset(1'b0);
    chk({c2, c1}, 16'h8000);
    do_reset(1'b1);
    chk(c2, 8'h00);
    // Standby mid-erase, then the wake wait
    wreg(1, 8'h04);
    wreg(0, 8'h42);
    tick(1);
    chk(epul, 1'b1);
    standby_req = 1'b1;
    tick(2);
    chk({halt, rdy, epul, c1, eb1}, 19'h40000);
    standby_req = 1'b0;
    tick(1900);
    chk(rdy, 1'b0);
    k = 0;
    while (rdy !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    chk(rdy, 1'b1);
    chk(k, fpec_pkg::WAKE_CYC - 1900);
    // Upper block register drives only the blocks above the first eight
    k = $random(seed) & 3;
    wreg(2, 8'h01 << k);
    wreg(0, 8'h42);
    tick(1);
    chk({eb2, etgt}, {4'(1 << k), 12'h100 << k});
    end_of_test();
  end
endmodule
bind fpec_top fpec_props #(.N_BLK_TWO(N_BLK_TWO)) u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .por_n(por_n), .standby_req(standby_req), .boot_running(boot_running),
  .flash_ctrl_one_q(flash_ctrl_one_q), .flash_ctrl_two_q(flash_ctrl_two_q),
  .ram_overlay_control_q(ram_overlay_control_q), .mode_q(mode_q),
  .program_pulse_q(program_pulse_q), .erase_pulse_q(erase_pulse_q),
  .erase_target_q(erase_target_q), .irq_block_q(irq_block_q), .latch_count_q(latch_count_q),
  .latch_full_q(latch_full_q), .flash_halt_q(flash_halt_q), .flash_ready_q(flash_ready_q));
